/* tmrc_pkg.sv */
/*
 * tmrc_pkg: shared constants and types for the test mode and reset
 * control block. Assumes a single 100 MHz system clock.
 */
package tmrc_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned SER_MAX_BPS   = 10_000_000;
   // shortest serial bit in system cycles, round down
   localparam int unsigned SER_BIT_CYC   = CLK_HZ / SER_MAX_BPS;
   localparam int unsigned POR_STEP_NS   = 1000;
   localparam int unsigned POR_STEP_CYC  = (POR_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned STEP_W        = 8;
   // core tick divider for each clock range
   localparam logic [3:0]  DIV_LOW_RANGE  = 4'h1;
   localparam logic [3:0]  DIV_HIGH_RANGE = 4'h2;

   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   localparam int unsigned SER_W         = 16;
   localparam logic [SER_W-1:0] SER_RESET = 16'h0000;

   // ------------------------------------------------------------
   // test select pin coding {primary, secondary}
   // ------------------------------------------------------------
   localparam logic [1:0] TSEL_NORMAL  = 2'h0;
   localparam logic [1:0] TSEL_FLOAT   = 2'h1;
   localparam logic [1:0] TSEL_PINMAP  = 2'h2;
   localparam logic [1:0] TSEL_DIGANA  = 2'h3;

   typedef enum logic [3:0] {
      TMRC_MODE_NORMAL = 4'h1,
      TMRC_MODE_PINMAP = 4'h2,
      TMRC_MODE_FLOAT  = 4'h4,
      TMRC_MODE_DIGANA = 4'h8
   } tmrc_mode_t;

   // power-on reset sequence, one-hot
   typedef enum logic [5:0] {
      TMRC_POR_RUN     = 6'h01,
      TMRC_POR_CLEAR   = 6'h02,
      TMRC_POR_FLOAT   = 6'h04,
      TMRC_POR_RECT    = 6'h08,
      TMRC_POR_RETRACT = 6'h10,
      TMRC_POR_BRAKE   = 6'h20
   } tmrc_por_t;

   typedef struct packed {
      logic regs_clear;
      logic spin_float;
      logic sync_rect_en;
      logic retract;
      logic brake;
   } tmrc_pwr_t;

   typedef struct packed {
      logic [SER_W-1:0] word;
      logic             valid;
   } tmrc_ser_word_t;

endpackage : tmrc_pkg

/* tmrc_serial_shifter.sv */
/*
 * tmrc_serial_shifter: shifts the bidirectional serial data line.
 * Assumes its pin inputs are already synchronised to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module tmrc_serial_shifter
   import tmrc_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             clear,
   // synchronised pins
   input  wire logic             sel_s,
   input  wire logic             sclk_s,
   input  wire logic             rw_s,
   input  wire logic             sdi_s,
   // user side
   input  wire logic [SER_W-1:0] rd_word,
   output tmrc_pkg::tmrc_ser_word_t wr_out,
   output logic                  sdo,
   output logic                  sdo_req
);
   import tmrc_pkg::*;

   typedef struct packed {
      logic             sclk_d;
      logic             sel_d;
      logic [SER_W-1:0] sh;
      logic             sdo;
      tmrc_ser_word_t   wr;
   } tmrc_shf_st_t;

   tmrc_shf_st_t st_q;
   tmrc_shf_st_t st_d;

   always_comb begin
      st_d          = st_q;
      st_d.sclk_d   = sclk_s;
      st_d.sel_d    = sel_s;
      st_d.wr.valid = 1'b0;
      if (clear) begin
         st_d.sh  = SER_RESET;
         st_d.sdo = 1'b0;
      end else if (sel_s && !st_q.sel_d) begin
         // read word captured at select, first bit out at once
         st_d.sh  = rw_s ? rd_word : SER_RESET;
         st_d.sdo = rw_s ? rd_word[SER_W-1] : 1'b0;
      end else if (sel_s) begin
         if (sclk_s && !st_q.sclk_d) begin
            st_d.sh = {st_q.sh[SER_W-2:0], sdi_s};
         end
         if (!sclk_s && st_q.sclk_d) begin
            st_d.sdo = st_q.sh[SER_W-1];
         end
      end else if (st_q.sel_d && !rw_s) begin
         st_d.wr.word  = st_q.sh;
         st_d.wr.valid = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wr_out  = st_q.wr;
   assign sdo     = st_q.sdo;
   assign sdo_req = sel_s & rw_s;

endmodule : tmrc_serial_shifter
`default_nettype wire

/* tmrc_top.sv */
/*
 * tmrc_top: test mode decode, low-voltage reset sequencing, clock range
 * prescale, serial port pins and synthesized speed output.
 * Assumes clk_sys is the system clock pin; all other pins are async.
 */
`timescale 1ns/1ps
`default_nettype none

module tmrc_top
   import tmrc_pkg::*;
(
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // test select pins
   input  wire logic               test_select_primary,
   input  wire logic               test_select_secondary,
   // supply and sleep
   input  wire logic               low_voltage_det,
   input  wire logic               sleep_mode,
   // control bits
   input  wire logic               clock_range_select,
   input  wire logic               speed_output_select,
   // serial port pins
   input  wire logic               chip_select_in,
   input  wire logic               serial_clk_in,
   input  wire logic               serial_rw_in,
   input  wire logic               serial_data_i,
   output logic                    serial_data_o,
   output logic                    serial_data_oe,
   // serial user side
   input  wire logic [SER_W-1:0]   serial_rd_word,
   output tmrc_pkg::tmrc_ser_word_t serial_wr,
   // motor phase comparators
   input  wire logic [2:0]         phase_zc,
   output logic                    synthesized_speed_out,
   output logic                    synthesized_speed_oe,
   // probe pins
   input  wire logic               digital_probe_src,
   input  wire logic               digital_probe_i,
   output logic                    digital_probe_o,
   output logic                    digital_probe_oe,
   output logic                    ext_fll_clk,
   output logic                    analog_probe_out,
   output logic                    pin_map_test,
   output tmrc_pkg::tmrc_mode_t    test_mode,
   // power stage control
   output tmrc_pkg::tmrc_pwr_t     pwr_ctl,
   output logic                    por_active,
   output logic                    core_tick
);
   import tmrc_pkg::*;

   localparam int unsigned NSYNC = 11;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NSYNC-1:0] sync1;
      logic [NSYNC-1:0] sync2;
      logic [2:0]       zc_d;
      tmrc_por_t        por;
      logic [STEP_W-1:0] step;
      logic [3:0]       div;
      logic             tick;
      logic             speed;
      tmrc_mode_t       mode;
      tmrc_pwr_t        pwr;
      logic             probe;
   } tmrc_st_t;

   tmrc_st_t st_q;
   tmrc_st_t st_d;

   function automatic tmrc_mode_t decode_mode(input logic [1:0] sel);
      unique case (sel)
         TSEL_NORMAL: decode_mode = TMRC_MODE_NORMAL;
         TSEL_PINMAP: decode_mode = TMRC_MODE_PINMAP;
         TSEL_FLOAT:  decode_mode = TMRC_MODE_FLOAT;
         TSEL_DIGANA: decode_mode = TMRC_MODE_DIGANA;
      endcase
   endfunction : decode_mode

   function automatic tmrc_pwr_t por_outputs(input tmrc_por_t s);
      tmrc_pwr_t p;
      p = '0;
      unique case (s)
         TMRC_POR_RUN:     p = '0;
         TMRC_POR_CLEAR:   p.regs_clear = 1'b1;
         TMRC_POR_FLOAT:   p = '{regs_clear: 1'b1, spin_float: 1'b1, default: 1'b0};
         TMRC_POR_RECT:    p = '{regs_clear: 1'b1, spin_float: 1'b1, sync_rect_en: 1'b1, default: 1'b0};
         TMRC_POR_RETRACT: p = '{brake: 1'b0, default: 1'b1};
         TMRC_POR_BRAKE:   p = '{default: 1'b1};
         default:          p = '{default: 1'b1};
      endcase
      return p;
   endfunction : por_outputs

   // ------------------------------------------------------------
   // synchronised pins
   // ------------------------------------------------------------
   logic       lv_s;
   logic [1:0] tsel_s;
   logic       sel_s;
   logic       sclk_s;
   logic       rw_s;
   logic       sdi_s;
   logic [2:0] zc_s;
   logic       dprobe_s;
   logic       float_pins;
   logic       shf_clear;
   logic       sdo;
   logic       sdo_req;

   assign {lv_s, tsel_s, sel_s, sclk_s, rw_s, sdi_s, zc_s, dprobe_s} = st_q.sync2;

   always_comb begin
      st_d       = st_q;
      st_d.sync1 = {low_voltage_det, test_select_primary, test_select_secondary,
                    chip_select_in, serial_clk_in, serial_rw_in, serial_data_i,
                    phase_zc, digital_probe_i};
      st_d.sync2 = st_q.sync1;
      st_d.zc_d  = zc_s;

      st_d.mode = decode_mode(tsel_s);

      st_d.step = st_q.step + 8'h01;
      unique case (st_q.por)
         TMRC_POR_RUN: begin
            st_d.step = '0;
            if (lv_s) begin
               st_d.por = TMRC_POR_CLEAR;
            end
         end
         TMRC_POR_CLEAR: begin
            if (st_q.step == STEP_W'(POR_STEP_CYC - 1)) begin
               st_d.por  = TMRC_POR_FLOAT;
               st_d.step = '0;
            end
         end
         TMRC_POR_FLOAT: begin
            if (st_q.step == STEP_W'(POR_STEP_CYC - 1)) begin
               st_d.por  = TMRC_POR_RECT;
               st_d.step = '0;
            end
         end
         TMRC_POR_RECT: begin
            if (st_q.step == STEP_W'(POR_STEP_CYC - 1)) begin
               st_d.por  = TMRC_POR_RETRACT;
               st_d.step = '0;
            end
         end
         TMRC_POR_RETRACT: begin
            if (st_q.step == STEP_W'(POR_STEP_CYC - 1)) begin
               st_d.por  = TMRC_POR_BRAKE;
               st_d.step = '0;
            end
         end
         TMRC_POR_BRAKE: begin
            // brake holds until the supply has recovered
            st_d.step = '0;
            if (!lv_s) begin
               st_d.por = TMRC_POR_RUN;
            end
         end
         default: begin
            st_d.por  = TMRC_POR_CLEAR;
            st_d.step = '0;
         end
      endcase
      st_d.pwr = por_outputs(st_d.por);

      st_d.tick = 1'b0;
      if (st_q.div >= (clock_range_select ? DIV_HIGH_RANGE : DIV_LOW_RANGE)) begin
         st_d.div  = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.div = st_q.div + 4'h1;
      end

      if (st_q.pwr.regs_clear) begin
         st_d.speed = 1'b0;
      end else if (speed_output_select) begin
         if (zc_s[0] != st_q.zc_d[0]) begin
            st_d.speed = ~st_q.speed;
         end
      end else if (zc_s != st_q.zc_d) begin
         st_d.speed = ~st_q.speed;
      end

      st_d.probe = digital_probe_src;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q       <= '0;
         st_q.por   <= TMRC_POR_CLEAR;
         st_q.mode  <= TMRC_MODE_NORMAL;
         st_q.pwr   <= '{regs_clear: 1'b1, default: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   assign shf_clear = st_q.pwr.regs_clear;

   tmrc_serial_shifter u_shifter (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .clear   (shf_clear),
      .sel_s   (sel_s),
      .sclk_s  (sclk_s),
      .rw_s    (rw_s),
      .sdi_s   (sdi_s),
      .rd_word (serial_rd_word),
      .wr_out  (serial_wr),
      .sdo     (sdo),
      .sdo_req (sdo_req)
   );

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // float test only floats logic pins, never the drives
   assign float_pins = sleep_mode | (st_q.por != TMRC_POR_RUN) | (st_q.mode == TMRC_MODE_FLOAT);

   assign serial_data_o  = sdo;
   assign serial_data_oe = sdo_req & ~float_pins;

   assign synthesized_speed_out = st_q.speed;
   assign synthesized_speed_oe  = ~float_pins;

   assign digital_probe_o  = st_q.probe;
   assign digital_probe_oe = (st_q.mode == TMRC_MODE_DIGANA);
   assign analog_probe_out = (st_q.mode == TMRC_MODE_DIGANA);
   assign ext_fll_clk      = dprobe_s & ~digital_probe_oe;

   assign pin_map_test = (st_q.mode == TMRC_MODE_PINMAP);
   assign test_mode    = st_q.mode;
   assign pwr_ctl      = st_q.pwr;
   assign por_active   = (st_q.por != TMRC_POR_RUN);
   assign core_tick    = st_q.tick;

endmodule : tmrc_top
`default_nettype wire

/* tmrc_host_model.sv */
/* tmrc_host_model: host that frames serial transfers toward tmrc_top.
   assumes the bench resolves the data line and calls xfer by hierarchy. */
`timescale 1ns/1ps
`default_nettype none

module tmrc_host_model
   import tmrc_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   // serial pins toward the device
   output logic      chip_select_in,
   output logic      serial_clk_in,
   output logic      serial_rw_in,
   output logic      host_bit,
   output logic      host_en,
   // resolved data line
   input  wire logic serial_data_i
);
   initial begin
      chip_select_in = 1'b0;
      serial_clk_in  = 1'b0;
      serial_rw_in   = 1'b0;
      host_bit       = 1'b0;
      host_en        = 1'b0;
   end

   // five cycles a half bit is exactly 10 Mbit/s
   task automatic half();
      repeat (5) @(negedge clk_sys);
   endtask : half

   // sel low sends clocks with the device unselected
   task automatic xfer(input logic sel, input logic rw, input logic [SER_W-1:0] wd,
                       output logic [SER_W-1:0] rd);
      rd = '0;
      @(negedge clk_sys);
      // direction set first, held all frame
      serial_rw_in   = rw;
      host_en        = !rw;
      chip_select_in = sel;
      half();
      for (int i = SER_W - 1; i >= 0; i--) begin
         host_bit = wd[i];
         half();
         serial_clk_in = 1'b1;
         rd[i]         = serial_data_i;
         half();
         serial_clk_in = 1'b0;
      end
      half();
      chip_select_in = 1'b0;
      half();
      host_en      = 1'b0;
      serial_rw_in = 1'b0;
   endtask : xfer
endmodule : tmrc_host_model

`default_nettype wire

/* tmrc_monitor.sv */
/* tmrc_monitor: concurrent checks on the ports of tmrc_top.
   assumes one clk_sys domain; bound into tmrc_top below. */
`timescale 1ns/1ps
`default_nettype none

module tmrc_monitor
   import tmrc_pkg::*;
(
   // clock and reset
   input wire logic           clk_sys,
   input wire logic           rst_n,
   // observed pins
   input wire logic           test_select_primary,
   input wire logic           test_select_secondary,
   input wire logic           sleep_mode,
   input wire logic           clock_range_select,
   input wire logic           speed_output_select,
   input wire logic           chip_select_in,
   input wire logic           serial_rw_in,
   input wire logic [2:0]     phase_zc,
   input wire logic           serial_data_oe,
   input wire tmrc_ser_word_t serial_wr,
   input wire logic           synthesized_speed_out,
   input wire logic           synthesized_speed_oe,
   input wire logic           digital_probe_oe,
   input wire logic           analog_probe_out,
   input wire logic           pin_map_test,
   input wire tmrc_mode_t     test_mode,
   input wire tmrc_pwr_t      pwr_ctl,
   input wire logic           por_active,
   input wire logic           core_tick
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_float_step;
      $rose(pwr_ctl.spin_float);
   endsequence
   sequence s_later_steps;
      ##100 $rose(pwr_ctl.sync_rect_en) ##100 $rose(pwr_ctl.retract) ##100 $rose(pwr_ctl.brake);
   endsequence
   // range held long first, so a switch in flight is not judged
   sequence s_low_tick;
      (!clock_range_select)[*8] ##0 core_tick ##1 (!clock_range_select)[*2];
   endsequence
   sequence s_high_tick;
      clock_range_select[*8] ##0 core_tick ##1 clock_range_select[*3];
   endsequence

   // pins settle through two flops and the mode register before the mode is judged
   a_mode_follow: assert property ($stable({test_select_primary, test_select_secondary})[*4] |->
      test_mode == (({test_select_primary, test_select_secondary} == TSEL_NORMAL) ? TMRC_MODE_NORMAL :
                    ({test_select_primary, test_select_secondary} == TSEL_PINMAP) ? TMRC_MODE_PINMAP :
                    ({test_select_primary, test_select_secondary} == TSEL_FLOAT)  ? TMRC_MODE_FLOAT  :
                    TMRC_MODE_DIGANA))
      else $error("test mode does not follow select pins");
   a_mode_pinmap: assert property ($stable(test_mode)[*3] |-> pin_map_test == (test_mode == TMRC_MODE_PINMAP))
      else $error("pin map flag disagrees with mode");
   a_probes_together: assert property ($stable(test_mode)[*3] |->
      (analog_probe_out && digital_probe_oe) == (test_mode == TMRC_MODE_DIGANA))
      else $error("probe pins not paired with test mode");
   a_data_float: assert property (sleep_mode || por_active |-> !serial_data_oe && !synthesized_speed_oe)
      else $error("pin driven in sleep or reset");
   a_read_only: assert property (serial_data_oe |-> $past(serial_rw_in, 2) && !por_active)
      else $error("data driven outside a read");
   a_por_order: assert property (s_float_step |-> s_later_steps)
      else $error("reset steps out of order or timing");
   a_por_accum: assert property (pwr_ctl.brake |-> pwr_ctl.retract && pwr_ctl.sync_rect_en && pwr_ctl.spin_float)
      else $error("brake applied before earlier steps");
   a_tick_low: assert property (s_low_tick |-> core_tick && !$past(core_tick))
      else $error("low range tick period wrong");
   a_tick_high: assert property (s_high_tick |-> core_tick && !$past(core_tick) && !$past(core_tick, 2))
      else $error("high range tick period wrong");
   a_speed_any: assert property ((!speed_output_select && !por_active)[*4] ##0 $changed(phase_zc) |->
      ##[3:5] $changed(synthesized_speed_out))
      else $error("speed output missed a phase edge");
   a_speed_a_only: assert property ((speed_output_select && $stable(phase_zc[0]) && !por_active)[*6] |->
      $stable(synthesized_speed_out))
      else $error("speed output moved without phase A");
   a_select_gate: assert property ((!chip_select_in)[*8] |-> !serial_wr.valid)
      else $error("write word while unselected");
endmodule : tmrc_monitor

bind tmrc_top tmrc_monitor mon_u (.*);

`default_nettype wire

/* tmrc_top_tb_top.sv */
/* tmrc_top_tb_top: directed scenarios for tmrc_top.
   assumes tmrc_host_model drives the serial pins, tmrc_monitor is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; $display("Error at %0t: got %h want %h", $time, (a), (e)); end end

module tmrc_top_tb_top;
   import tmrc_pkg::*;
   // ----------------------------------------
   // pins and bookkeeping
   // ----------------------------------------
   logic             clk_sys = 1'b0;
   logic             rst_n = 1'b0;
   logic             test_select_primary = 1'b0;
   logic             test_select_secondary = 1'b0;
   logic             low_voltage_det = 1'b0;
   logic             sleep_mode = 1'b0;
   logic             clock_range_select = 1'b0;
   logic             speed_output_select = 1'b0;
   logic [2:0]       phase_zc = 3'h0;
   logic             digital_probe_src = 1'b0;
   logic             digital_probe_i = 1'b1;
   logic [SER_W-1:0] serial_rd_word = 16'h0000;
   logic             chip_select_in, serial_clk_in, serial_rw_in, host_bit, host_en;
   logic             serial_data_i, serial_data_o, serial_data_oe;
   logic             synthesized_speed_out, synthesized_speed_oe, digital_probe_o;
   logic             digital_probe_oe, ext_fll_clk, analog_probe_out, pin_map_test;
   logic             por_active, core_tick;
   tmrc_ser_word_t   serial_wr;
   tmrc_mode_t       test_mode;
   tmrc_pwr_t        pwr_ctl;
   logic [SER_W-1:0] wr_word;
   int               wr_cnt = 0;
   int               err_count = 0;
   int               samples_checked = 0;

   always #5 clk_sys = ~clk_sys;
   // a released line shows the inverse of what the device would drive, never a held value
   assign serial_data_i = serial_data_oe ? serial_data_o : (host_en ? host_bit : ~serial_data_o);
   always @(posedge clk_sys) begin
      if (serial_wr.valid === 1'b1) begin
         wr_word <= serial_wr.word;
         wr_cnt  <= wr_cnt + 1;
      end
   end

   tmrc_top dut_u (.*);
   tmrc_host_model host_u (.*);

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wait_cyc

   task automatic test_done();
      $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   task automatic wait_por_done();
      int n;
      n = 0;
      while (por_active !== 1'b0 && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 1000) begin
         err_count++;
         $display("Error at %0t: reset sequence never ended", $time);
         test_done();
      end
   endtask : wait_por_done

   task automatic t_modes();
      tmrc_mode_t map [4] = '{TMRC_MODE_NORMAL, TMRC_MODE_FLOAT, TMRC_MODE_PINMAP, TMRC_MODE_DIGANA};
      tmrc_pwr_t  pwr0;
      pwr0 = pwr_ctl;
      for (int m = 0; m < 4; m++) begin
         {test_select_primary, test_select_secondary} = 2'(m);
         digital_probe_src = m[0];
         wait_cyc(8);
         `CHK(test_mode, map[m])
         `CHK(pin_map_test, m == 2)
         `CHK(digital_probe_o, m[0])
         `CHK(synthesized_speed_oe, m != 1)
         `CHK(analog_probe_out & digital_probe_oe, m == 3)
         `CHK(ext_fll_clk, m != 3)
         `CHK(pwr_ctl, pwr0)
      end
      {test_select_primary, test_select_secondary} = 2'h0;
      wait_cyc(8);
   endtask : t_modes

   task automatic t_speed();
      logic s0;
      for (int p = 0; p < 6; p++) begin
         speed_output_select = (p > 2);
         wait_cyc(8);
         s0 = synthesized_speed_out;
         phase_zc[p % 3] = ~phase_zc[p % 3];
         wait_cyc(8);
         `CHK(synthesized_speed_out, s0 ^ (p <= 3))
      end
   endtask : t_speed

   task automatic t_tick();
      int n;
      for (int r = 0; r < 2; r++) begin
         clock_range_select = r[0];
         wait_cyc(10);
         n = 0;
         repeat (60) begin
            @(negedge clk_sys);
            n += int'(core_tick);
         end
         `CHK(n, r ? 20 : 30)
      end
   endtask : t_tick

   task automatic t_serial();
      logic [SER_W-1:0] rd;
      int               n0;
      host_u.xfer(1'b1, 1'b0, 16'ha53c, rd);
      wait_cyc(8);
      `CHK(wr_word, 16'ha53c)
      serial_rd_word = 16'h3cc5;
      host_u.xfer(1'b1, 1'b1, 16'h0000, rd);
      `CHK(rd, 16'h3cc5)
      wait_cyc(8);
      n0 = wr_cnt;
      host_u.xfer(1'b0, 1'b0, 16'hffff, rd);
      wait_cyc(8);
      `CHK(wr_cnt, n0)
      host_u.xfer(1'b1, 1'b0, 16'h8001, rd);
      host_u.xfer(1'b1, 1'b0, 16'h7ffe, rd);
      wait_cyc(8);
      `CHK(wr_word, 16'h7ffe)
      `CHK(wr_cnt, n0 + 2)
      sleep_mode = 1'b1;
      serial_rd_word = 16'hffff;
      host_u.xfer(1'b1, 1'b1, 16'h0000, rd);
      `CHK(rd == 16'hffff, 1'b0)
      `CHK(synthesized_speed_oe, 1'b0)
      sleep_mode = 1'b0;
      wait_cyc(8);
   endtask : t_serial

   task automatic t_por();
      tmrc_pwr_t exp;
      low_voltage_det = 1'b1;
      wait_cyc(10);
      for (int s = 0; s < 5; s++) begin
         exp = 5'h1f << (4 - s);
         `CHK(pwr_ctl, exp)
         `CHK(serial_data_oe | synthesized_speed_oe, 1'b0)
         wait_cyc(100);
      end
      `CHK(por_active, 1'b1)
      low_voltage_det = 1'b0;
      wait_por_done();
   endtask : t_por

   initial begin
      wait_cyc(2);
      rst_n = 1'b1;
      wait_por_done();
      t_modes();
      t_speed();
      t_tick();
      t_serial();
      t_por();
      test_done();
   end
endmodule : tmrc_top_tb_top

`default_nettype wire
